// File: pkg/lapd_pkg.sv
// Shared types and constants for the mode-setting link entities
package lapd_pkg;

	// ********************************************
	// Frame description on the abstract link
	// ********************************************
	typedef enum logic [2:0] {
		FK_SABME = 3'h0, // Set asynchronous balanced mode extended
		FK_DISC  = 3'h1, // Disconnect command
		FK_UA    = 3'h2, // Unnumbered acknowledge
		FK_DM    = 3'h3, // Disconnected mode response
		FK_UI    = 3'h4, // Unnumbered information
		FK_INFO  = 3'h5, // Numbered information frame
		FK_SUPV  = 3'h6  // Supervisory frame
	} frame_kind_type;

	typedef struct packed {
		logic           valid; // One-cycle strobe
		frame_kind_type kind;  // Frame type
		logic           pf;    // Poll or final bit
	} frame_type;

	// ********************************************
	// Link states
	// ********************************************
	typedef enum logic [1:0] {
		ST_TEI       = 2'h0, // TEI assigned, no multiple-frame mode
		ST_AWAIT_EST = 2'h1, // SABME sent, waiting for answer
		ST_AWAIT_REL = 2'h2, // DISC sent, waiting for answer
		ST_EST       = 2'h3  // Multiple-frame established
	} link_state_type;

	// ********************************************
	// Timing and retry constants
	// ********************************************
	localparam int         CLK_MHZ     = 250;               // Core clock rate
	localparam int         T200_US     = 1000;              // Answer supervision time
	localparam int         T203_US     = 10000;             // Idle supervision time
	localparam int         T200_CYCLES = T200_US * CLK_MHZ; // Cycles of T200
	localparam int         T203_CYCLES = T203_US * CLK_MHZ; // Cycles of T203
	localparam int         N200_MAX    = 3;                 // Retransmission limit
	localparam int         TMR_W       = 32;                // Timer counter width
	localparam logic [3:0] RETRY_RST   = 4'h0;              // Retry count after reset
	localparam logic       PF_SET      = 1'b1;              // Poll on commands
	localparam logic       PF_CLR      = 1'b0;              // Cleared poll or final

endpackage : lapd_pkg

// File: pkg/lapd_link_if.sv
// Frame-level link joining the network-side and user-side entities
`timescale 1ns/1ps
`default_nettype none
interface lapd_link_if;

	lapd_pkg::frame_type n2u; // Frames from network end to user end
	lapd_pkg::frame_type u2n; // Frames from user end to network end

	// Network-side entity
	modport net_end (
		output n2u,
		input  u2n
	);

	// User-side entity
	modport usr_end (
		input  n2u,
		output u2n
	);

endinterface : lapd_link_if
`default_nettype wire

// File: rtl/usr_entity.sv
// User-side entity: compact mode-setting state machine
`timescale 1ns/1ps
`default_nettype none
module usr_entity #(
	parameter int T200_CYC = lapd_pkg::T200_CYCLES, // Answer supervision cycles
	parameter int T203_CYC = lapd_pkg::T203_CYCLES  // Idle supervision cycles
) (
	input  wire logic      sys_clk,
	input  wire logic      nrst,
	lapd_link_if.usr_end   lnk,
	input  wire logic      est_req,
	input  wire logic      rel_req,
	input  wire logic      accept_ok,
	output logic           est_ind,
	output logic           est_cnf,
	output logic           rel_ind,
	output logic           rel_cnf,
	output logic           mdl_err,
	output logic           ui_rcvd,
	output logic           seq_clear,
	output logic           data_discard,
	output logic           idle_exp,
	output logic           link_up
);

	localparam logic [31:0] T200_LOAD = 32'(T200_CYC - 1); // Timer reload
	localparam logic [31:0] T203_LOAD = 32'(T203_CYC - 1); // Idle reload

	// All state in one record
	typedef struct packed {
		lapd_pkg::link_state_type st;
		logic [3:0]               retry;
		logic                     t200_on;
		logic [31:0]              t200_cnt;
		logic                     t203_on;
		logic [31:0]              t203_cnt;
		lapd_pkg::frame_type      tx;
		logic                     est_ind;
		logic                     est_cnf;
		logic                     rel_ind;
		logic                     rel_cnf;
		logic                     mdl_err;
		logic                     ui_rcvd;
		logic                     seq_clear;
		logic                     data_discard;
		logic                     idle_exp;
		logic                     link_up;
	} usr_state_type;

	usr_state_type       s_r;  // Registered state
	usr_state_type       s_nxt; // Next state
	lapd_pkg::frame_type rx;   // Incoming frame

	assign rx = lnk.n2u;

	// ********************************************
	// Next-state logic
	// ********************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.tx = '0;
		{s_nxt.est_ind, s_nxt.est_cnf, s_nxt.rel_ind, s_nxt.rel_cnf} = 4'h0;
		{s_nxt.mdl_err, s_nxt.ui_rcvd, s_nxt.seq_clear, s_nxt.data_discard, s_nxt.idle_exp} = 5'h00;
		// Timers count down to zero and hold
		if (s_r.t200_on && s_r.t200_cnt != 32'h0) begin
			s_nxt.t200_cnt = s_r.t200_cnt - 32'h1;
		end
		if (s_r.t203_on && s_r.t203_cnt != 32'h0) begin
			s_nxt.t203_cnt = s_r.t203_cnt - 32'h1;
		end
		if (rx.valid) begin
			case (s_r.st)
				lapd_pkg::ST_TEI: begin
					if (rx.kind == lapd_pkg::FK_SABME && accept_ok) begin
						s_nxt.tx = '{1'b1, lapd_pkg::FK_UA, rx.pf};
						s_nxt.st = lapd_pkg::ST_EST;
						{s_nxt.seq_clear, s_nxt.est_ind, s_nxt.t203_on} = 3'h7;
						s_nxt.t203_cnt = T203_LOAD;
						s_nxt.retry = lapd_pkg::RETRY_RST;
					end else if (rx.kind == lapd_pkg::FK_SABME || rx.kind == lapd_pkg::FK_DISC) begin
						s_nxt.tx = '{1'b1, lapd_pkg::FK_DM, rx.pf};
					end else if (rx.kind == lapd_pkg::FK_UA || (rx.kind == lapd_pkg::FK_DM && rx.pf)) begin
						s_nxt.mdl_err = 1'b1;
					end else if (rx.kind == lapd_pkg::FK_UI) begin
						s_nxt.ui_rcvd = 1'b1;
					end else if ((rx.kind == lapd_pkg::FK_INFO || rx.kind == lapd_pkg::FK_SUPV) && rx.pf) begin
						s_nxt.tx = '{1'b1, lapd_pkg::FK_DM, lapd_pkg::PF_SET};
					end
				end
				lapd_pkg::ST_AWAIT_EST, lapd_pkg::ST_AWAIT_REL: begin
					if ((rx.kind == lapd_pkg::FK_UA || rx.kind == lapd_pkg::FK_DM) && rx.pf) begin
						s_nxt.t200_on = 1'b0;
						if (s_r.st == lapd_pkg::ST_AWAIT_REL) begin
							s_nxt.st = lapd_pkg::ST_TEI;
							s_nxt.rel_cnf = 1'b1;
						end else if (rx.kind == lapd_pkg::FK_UA) begin
							s_nxt.st = lapd_pkg::ST_EST;
							{s_nxt.seq_clear, s_nxt.est_cnf, s_nxt.t203_on} = 3'h7;
							s_nxt.t203_cnt = T203_LOAD;
						end else begin
							s_nxt.st = lapd_pkg::ST_TEI;
							s_nxt.rel_ind = 1'b1;
						end
					end else if (rx.kind == lapd_pkg::FK_SABME || rx.kind == lapd_pkg::FK_DISC) begin
						// Same command answers UA, crossed commands answer DM
						if ((rx.kind == lapd_pkg::FK_SABME) == (s_r.st == lapd_pkg::ST_AWAIT_EST)) begin
							s_nxt.tx = '{1'b1, lapd_pkg::FK_UA, rx.pf};
						end else begin
							s_nxt.tx = '{1'b1, lapd_pkg::FK_DM, rx.pf};
						end
					end else if (rx.kind == lapd_pkg::FK_UI) begin
						s_nxt.ui_rcvd = 1'b1;
					end
					// DM with final 0 and non-unnumbered frames fall through
				end
				lapd_pkg::ST_EST: begin
					if (rx.kind == lapd_pkg::FK_SABME) begin
						s_nxt.tx = '{1'b1, accept_ok ? lapd_pkg::FK_UA : lapd_pkg::FK_DM, rx.pf};
						s_nxt.seq_clear = accept_ok;
						s_nxt.est_ind = accept_ok;
						s_nxt.rel_ind = !accept_ok;
						s_nxt.t203_cnt = T203_LOAD;
						s_nxt.t203_on = accept_ok;
						s_nxt.retry = lapd_pkg::RETRY_RST;
						s_nxt.st = accept_ok ? lapd_pkg::ST_EST : lapd_pkg::ST_TEI;
					end else if (rx.kind == lapd_pkg::FK_DISC) begin
						s_nxt.tx = '{1'b1, lapd_pkg::FK_UA, rx.pf};
						s_nxt.rel_ind = 1'b1;
						s_nxt.t203_on = 1'b0;
						s_nxt.st = lapd_pkg::ST_TEI;
					end else if (rx.kind == lapd_pkg::FK_UI) begin
						s_nxt.ui_rcvd = 1'b1;
					end
				end
				default: s_nxt.st = lapd_pkg::ST_TEI;
			endcase
		end else if ((s_r.st == lapd_pkg::ST_AWAIT_EST || s_r.st == lapd_pkg::ST_AWAIT_REL) &&
				s_r.t200_on && s_r.t200_cnt == 32'h0) begin
			if (s_r.retry == 4'(lapd_pkg::N200_MAX)) begin
				s_nxt.t200_on = 1'b0;
				s_nxt.mdl_err = 1'b1;
				s_nxt.rel_ind = s_r.st == lapd_pkg::ST_AWAIT_EST;
				s_nxt.data_discard = s_r.st == lapd_pkg::ST_AWAIT_EST;
				s_nxt.rel_cnf = s_r.st == lapd_pkg::ST_AWAIT_REL;
				s_nxt.st = lapd_pkg::ST_TEI;
			end else begin
				s_nxt.tx = '{1'b1, s_r.st == lapd_pkg::ST_AWAIT_EST ? lapd_pkg::FK_SABME : lapd_pkg::FK_DISC,
					lapd_pkg::PF_SET};
				s_nxt.t200_cnt = T200_LOAD;
				s_nxt.retry = s_r.retry + 4'h1;
			end
		end else if (est_req && (s_r.st == lapd_pkg::ST_TEI || s_r.st == lapd_pkg::ST_EST)) begin
			s_nxt.tx = '{1'b1, lapd_pkg::FK_SABME, lapd_pkg::PF_SET};
			{s_nxt.seq_clear, s_nxt.data_discard, s_nxt.t200_on} = 3'h7;
			s_nxt.t200_cnt = T200_LOAD;
			s_nxt.t203_on = 1'b0;
			s_nxt.retry = lapd_pkg::RETRY_RST;
			s_nxt.st = lapd_pkg::ST_AWAIT_EST;
		end else if (rel_req && s_r.st == lapd_pkg::ST_EST) begin
			s_nxt.tx = '{1'b1, lapd_pkg::FK_DISC, lapd_pkg::PF_SET};
			{s_nxt.data_discard, s_nxt.t200_on} = 2'h3;
			s_nxt.t200_cnt = T200_LOAD;
			s_nxt.t203_on = 1'b0;
			s_nxt.retry = lapd_pkg::RETRY_RST;
			s_nxt.st = lapd_pkg::ST_AWAIT_REL;
		end else if (s_r.st == lapd_pkg::ST_EST && s_r.t203_on && s_r.t203_cnt == 32'h0) begin
			s_nxt.idle_exp = 1'b1;
			s_nxt.t203_cnt = T203_LOAD;
		end
		// Link level held in its own flop
		s_nxt.link_up = s_nxt.st == lapd_pkg::ST_EST;
	end

	// State register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lnk.u2n      = s_r.tx;
	assign est_ind      = s_r.est_ind;
	assign est_cnf      = s_r.est_cnf;
	assign rel_ind      = s_r.rel_ind;
	assign rel_cnf      = s_r.rel_cnf;
	assign mdl_err      = s_r.mdl_err;
	assign ui_rcvd      = s_r.ui_rcvd;
	assign seq_clear    = s_r.seq_clear;
	assign data_discard = s_r.data_discard;
	assign idle_exp     = s_r.idle_exp;
	assign link_up      = s_r.link_up;

endmodule : usr_entity
`default_nettype wire

// File: rtl/net_entity.sv
// Network-side entity: mode-setting state machine of the link layer
`timescale 1ns/1ps
`default_nettype none
// Function
// - Establish: send SABME, clear, reset count, T200
// - SABME and DISC always carry poll 1
// - Layer 3 establish discards pending data
// - Accept SABME: UA, zero vars, indicate, T203
// - Refused SABME answered DM echoing poll
// - UA final 1 establishes and confirms
// - DM final 1 releases; DM final 0 ignored
// - T200 expiry resends SABME, counts retry
// - N200 retries: discard, release, error, idle
// - Established exchanges frames; SABME re-establishes
// - Release ignores non-unnumbered, discards data
// - Release: DISC poll 1, T200, reset count
// - DISC when established: UA, release indication
// - UA/DM final 1 after DISC confirms release
// - T200 expiry resends DISC, counts retry
// - N200 DISC tries: error, idle, confirm
// - Idle: DISC gets DM, SABME establishes
// - Idle: stray UA/DM final 1 flags error
// - Idle: polled I/S frame gets DM
// - Same commands crossing: UA, confirm on UA
// - Crossed different commands: DM, release
// - DM final 0 colliding with command ignored
module net_entity #(
	parameter int T200_CYC = lapd_pkg::T200_CYCLES, // Answer supervision cycles
	parameter int T203_CYC = lapd_pkg::T203_CYCLES  // Idle supervision cycles
) (
	input  wire logic      sys_clk,
	input  wire logic      nrst,
	lapd_link_if.net_end   lnk,
	input  wire logic      est_req,
	input  wire logic      rel_req,
	input  wire logic      accept_ok,
	output logic           est_ind,
	output logic           est_cnf,
	output logic           rel_ind,
	output logic           rel_cnf,
	output logic           mdl_err,
	output logic           ui_rcvd,
	output logic           seq_clear,
	output logic           data_discard,
	output logic           idle_exp,
	output logic           link_up
);

	// ********************************************
	// Constants
	// ********************************************
	localparam logic [31:0] T200_LOAD = 32'(T200_CYC - 1); // T200 reload value
	localparam logic [31:0] T203_LOAD = 32'(T203_CYC - 1); // T203 reload value
	localparam logic [3:0]  N200_LIM  = 4'(lapd_pkg::N200_MAX); // Retry limit

	// ********************************************
	// State record
	// ********************************************
	typedef struct packed {
		lapd_pkg::link_state_type st;           // Link state
		logic [3:0]               retry;        // Retransmission counter
		logic                     t200_on;      // T200 running
		logic [31:0]              t200_cnt;     // T200 remaining cycles
		logic                     t203_on;      // T203 running
		logic [31:0]              t203_cnt;     // T203 remaining cycles
		lapd_pkg::frame_type      tx;           // Frame being sent
		logic                     est_ind;      // Establish indication
		logic                     est_cnf;      // Establish confirm
		logic                     rel_ind;      // Release indication
		logic                     rel_cnf;      // Release confirm
		logic                     mdl_err;      // Management error
		logic                     ui_rcvd;      // UI frame for upper layer
		logic                     seq_clear;    // Zero V(S), V(R), V(A), conditions
		logic                     data_discard; // Flush data queue
		logic                     idle_exp;     // T203 ran out
		logic                     link_up;      // Established level
	} net_state_type;

	net_state_type       s_r;   // Registered state
	net_state_type       s_nxt; // Next state
	lapd_pkg::frame_type rx;    // Frame from the far end
	logic                await; // Waiting for answer to a command
	logic                t200_exp; // T200 has run out

	// Far end sits on the same clock, so no synchroniser
	assign rx       = lnk.u2n;
	assign await    = s_r.st == lapd_pkg::ST_AWAIT_EST || s_r.st == lapd_pkg::ST_AWAIT_REL;
	assign t200_exp = s_r.t200_on && s_r.t200_cnt == 32'h0;

	// ********************************************
	// Next-state logic
	// ********************************************
	// Received frame wins over T200, T200 over requests, requests over T203;
	// a request meeting a frame is dropped, one frame leaves per cycle
	always_comb begin
		s_nxt = s_r;
		s_nxt.tx = '0;
		{s_nxt.est_ind, s_nxt.est_cnf, s_nxt.rel_ind, s_nxt.rel_cnf} = 4'h0;
		{s_nxt.mdl_err, s_nxt.ui_rcvd, s_nxt.seq_clear, s_nxt.data_discard, s_nxt.idle_exp} = 5'h00;
		// Count down and hold at zero until serviced
		if (s_r.t200_on && s_r.t200_cnt != 32'h0) begin
			s_nxt.t200_cnt = s_r.t200_cnt - 32'h1;
		end
		if (s_r.t203_on && s_r.t203_cnt != 32'h0) begin
			s_nxt.t203_cnt = s_r.t203_cnt - 32'h1;
		end
		if (rx.valid) begin
			case (s_r.st)
				// Idle: no multiple-frame mode
				lapd_pkg::ST_TEI: begin
					if (rx.kind == lapd_pkg::FK_SABME && accept_ok) begin
						s_nxt.tx = '{1'b1, lapd_pkg::FK_UA, rx.pf};
						s_nxt.st = lapd_pkg::ST_EST;
						s_nxt.seq_clear = 1'b1;
						s_nxt.est_ind = 1'b1;
						s_nxt.t203_on = 1'b1;
						s_nxt.t203_cnt = T203_LOAD;
						s_nxt.retry = lapd_pkg::RETRY_RST;
					end else if (rx.kind == lapd_pkg::FK_SABME) begin
						s_nxt.tx = '{1'b1, lapd_pkg::FK_DM, rx.pf};
					end else if (rx.kind == lapd_pkg::FK_DISC) begin
						s_nxt.tx = '{1'b1, lapd_pkg::FK_DM, rx.pf};
					end else if (rx.kind == lapd_pkg::FK_UA || (rx.kind == lapd_pkg::FK_DM && rx.pf)) begin
						// Possible duplicate TEI on the line
						s_nxt.mdl_err = 1'b1;
					end else if (rx.kind == lapd_pkg::FK_UI) begin
						s_nxt.ui_rcvd = 1'b1;
					end else if ((rx.kind == lapd_pkg::FK_INFO || rx.kind == lapd_pkg::FK_SUPV) && rx.pf) begin
						s_nxt.tx = '{1'b1, lapd_pkg::FK_DM, lapd_pkg::PF_SET};
					end
					// DM with final 0 and unpolled I and S frames are dropped
				end
				// Command outstanding
				lapd_pkg::ST_AWAIT_EST, lapd_pkg::ST_AWAIT_REL: begin
					if ((rx.kind == lapd_pkg::FK_UA || rx.kind == lapd_pkg::FK_DM) && rx.pf) begin
						s_nxt.t200_on = 1'b0;
						if (s_r.st == lapd_pkg::ST_AWAIT_REL) begin
							s_nxt.st = lapd_pkg::ST_TEI;
							s_nxt.rel_cnf = 1'b1;
						end else if (rx.kind == lapd_pkg::FK_UA) begin
							s_nxt.st = lapd_pkg::ST_EST;
							s_nxt.seq_clear = 1'b1;
							s_nxt.est_cnf = 1'b1;
							s_nxt.t203_on = 1'b1;
							s_nxt.t203_cnt = T203_LOAD;
						end else begin
							s_nxt.st = lapd_pkg::ST_TEI;
							s_nxt.rel_ind = 1'b1;
						end
					end else if (rx.kind == lapd_pkg::FK_SABME || rx.kind == lapd_pkg::FK_DISC) begin
						// Crossing commands: answer at once, state moves on the reply
						if ((rx.kind == lapd_pkg::FK_SABME) == (s_r.st == lapd_pkg::ST_AWAIT_EST)) begin
							s_nxt.tx = '{1'b1, lapd_pkg::FK_UA, rx.pf};
						end else begin
							s_nxt.tx = '{1'b1, lapd_pkg::FK_DM, rx.pf};
						end
					end else if (rx.kind == lapd_pkg::FK_UI) begin
						s_nxt.ui_rcvd = 1'b1;
					end
					// DM final 0 is ignored here, a stray LAPB-style prompt
					// I and S frames are ignored while mode is being set
				end
				// Multiple-frame operation
				lapd_pkg::ST_EST: begin
					if (rx.kind == lapd_pkg::FK_SABME) begin
						// Re-establishment by the far end
						s_nxt.tx = '{1'b1, accept_ok ? lapd_pkg::FK_UA : lapd_pkg::FK_DM, rx.pf};
						s_nxt.seq_clear = accept_ok;
						s_nxt.est_ind = accept_ok;
						s_nxt.rel_ind = !accept_ok;
						s_nxt.t203_on = accept_ok;
						s_nxt.t203_cnt = T203_LOAD;
						s_nxt.retry = lapd_pkg::RETRY_RST;
						s_nxt.st = accept_ok ? lapd_pkg::ST_EST : lapd_pkg::ST_TEI;
					end else if (rx.kind == lapd_pkg::FK_DISC) begin
						s_nxt.tx = '{1'b1, lapd_pkg::FK_UA, rx.pf};
						s_nxt.rel_ind = 1'b1;
						s_nxt.t203_on = 1'b0;
						s_nxt.st = lapd_pkg::ST_TEI;
					end else if (rx.kind == lapd_pkg::FK_UI) begin
						s_nxt.ui_rcvd = 1'b1;
					end
					// I and S frames go to the transfer logic, not here
				end
				default: begin
					s_nxt.st = lapd_pkg::ST_TEI;
				end
			endcase
		end else if (await && t200_exp) begin
			if (s_r.retry == N200_LIM) begin
				// Out of retries: give up the link
				s_nxt.t200_on = 1'b0;
				s_nxt.mdl_err = 1'b1;
				s_nxt.rel_ind = s_r.st == lapd_pkg::ST_AWAIT_EST;
				s_nxt.data_discard = s_r.st == lapd_pkg::ST_AWAIT_EST;
				s_nxt.rel_cnf = s_r.st == lapd_pkg::ST_AWAIT_REL;
				s_nxt.st = lapd_pkg::ST_TEI;
			end else begin
				// Resend the same command with poll set
				s_nxt.tx = '{1'b1, s_r.st == lapd_pkg::ST_AWAIT_EST ? lapd_pkg::FK_SABME : lapd_pkg::FK_DISC,
					lapd_pkg::PF_SET};
				s_nxt.t200_cnt = T200_LOAD;
				s_nxt.retry = s_r.retry + 4'h1;
			end
		end else if (est_req && (s_r.st == lapd_pkg::ST_TEI || s_r.st == lapd_pkg::ST_EST)) begin
			s_nxt.tx = '{1'b1, lapd_pkg::FK_SABME, lapd_pkg::PF_SET};
			s_nxt.seq_clear = 1'b1;
			s_nxt.data_discard = 1'b1;
			s_nxt.retry = lapd_pkg::RETRY_RST;
			s_nxt.t200_on = 1'b1;
			s_nxt.t200_cnt = T200_LOAD;
			s_nxt.t203_on = 1'b0;
			s_nxt.st = lapd_pkg::ST_AWAIT_EST;
		end else if (rel_req && s_r.st == lapd_pkg::ST_EST) begin
			s_nxt.tx = '{1'b1, lapd_pkg::FK_DISC, lapd_pkg::PF_SET};
			s_nxt.data_discard = 1'b1;
			s_nxt.retry = lapd_pkg::RETRY_RST;
			s_nxt.t200_on = 1'b1;
			s_nxt.t200_cnt = T200_LOAD;
			s_nxt.t203_on = 1'b0;
			s_nxt.st = lapd_pkg::ST_AWAIT_REL;
		end else if (s_r.st == lapd_pkg::ST_EST && s_r.t203_on && s_r.t203_cnt == 32'h0) begin
			// Idle supervision; recovery is left to the transfer logic
			s_nxt.idle_exp = 1'b1;
			s_nxt.t203_cnt = T203_LOAD;
		end
		// Registered so the level cannot glitch on a state decode
		s_nxt.link_up = s_nxt.st == lapd_pkg::ST_EST;
	end

	// ********************************************
	// State register
	// ********************************************
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the record
	assign lnk.n2u      = s_r.tx;
	assign est_ind      = s_r.est_ind;
	assign est_cnf      = s_r.est_cnf;
	assign rel_ind      = s_r.rel_ind;
	assign rel_cnf      = s_r.rel_cnf;
	assign mdl_err      = s_r.mdl_err;
	assign ui_rcvd      = s_r.ui_rcvd;
	assign seq_clear    = s_r.seq_clear;
	assign data_discard = s_r.data_discard;
	assign idle_exp     = s_r.idle_exp;
	assign link_up      = s_r.link_up;

endmodule : net_entity
`default_nettype wire

// File: dv/lapd_link_monitor.sv
// Checker of frame relations on the link joining the two entities
`timescale 1ns/1ps
`default_nettype none
module lapd_link_monitor (
	input wire logic                sys_clk,
	input wire logic                nrst,
	input wire lapd_pkg::frame_type n2u,
	input wire lapd_pkg::frame_type u2n
);
	// ********************************
	// Frame classes
	// ********************************
	wire logic n_cmd = n2u.valid && (n2u.kind == lapd_pkg::FK_SABME || n2u.kind == lapd_pkg::FK_DISC); // Net command
	wire logic u_cmd = u2n.valid && (u2n.kind == lapd_pkg::FK_SABME || u2n.kind == lapd_pkg::FK_DISC); // User command
	wire logic n_rsp = n2u.valid && (n2u.kind == lapd_pkg::FK_UA || n2u.kind == lapd_pkg::FK_DM);      // Net response
	wire logic u_rsp = u2n.valid && (u2n.kind == lapd_pkg::FK_UA || u2n.kind == lapd_pkg::FK_DM);      // User response
	// ********************************
	// Relations
	// ********************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_net_cmd_poll: assert property (n_cmd |-> n2u.pf) else $error("net command lacks poll");
	a_usr_cmd_poll: assert property (u_cmd |-> u2n.pf) else $error("user command lacks poll");
	a_net_sabme_reply: assert property (u_cmd && u2n.kind == lapd_pkg::FK_SABME |=> n_rsp && n2u.pf == $past(u2n.pf))
		else $error("net SABME answer wrong");
	a_usr_sabme_reply: assert property (n_cmd && n2u.kind == lapd_pkg::FK_SABME |=> u_rsp && u2n.pf == $past(n2u.pf))
		else $error("user SABME answer wrong");
	a_net_disc_reply: assert property (u_cmd && u2n.kind == lapd_pkg::FK_DISC |=> n_rsp && n2u.pf == $past(u2n.pf))
		else $error("net DISC answer wrong");
	a_usr_disc_reply: assert property (n_cmd && n2u.kind == lapd_pkg::FK_DISC |=> u_rsp && u2n.pf == $past(n2u.pf))
		else $error("user DISC answer wrong");
	// Crossed different commands are both refused
	a_cross_cmd_dm: assert property (n_cmd && u_cmd && n2u.kind != u2n.kind |=> n_rsp && u_rsp
		&& n2u.kind == lapd_pkg::FK_DM && u2n.kind == lapd_pkg::FK_DM) else $error("crossed commands not refused");
	// A user response never provokes a net frame in the next cycle
	a_rsp_no_reply: assert property (u_rsp |=> !n2u.valid) else $error("net answered a response");
endmodule : lapd_link_monitor
`default_nettype wire

// File: dv/lapd_mode_setting_fsm_test.sv
// Self-checking bench for the paired mode-setting entities
`timescale 1ns/1ps
`default_nettype none
module lapd_mode_setting_fsm_test;
	localparam int T2 = 20; // Short answer supervision
	localparam int T3 = 50; // Short idle supervision
	logic       sys_clk   = 1'b0;
	logic       nrst      = 1'b0;
	logic [2:0] ni        = 3'h1; // Net {est_req, rel_req, accept_ok}
	logic [2:0] ui        = 3'h1; // User requests
	logic [2:0] bi        = 3'h1; // Lone net requests
	logic [9:0] no, uo, bo;      // Primitive outputs
	int         fails     = 0;
	int         cmp_count = 0;
	lapd_link_if lk_a ();        // Entity to entity
	lapd_link_if lk_b ();        // Bench plays the peer
	net_entity #(.T200_CYC(T2), .T203_CYC(T3)) net_entity_i (.sys_clk(sys_clk), .nrst(nrst), .lnk(lk_a.net_end),
		.est_req(ni[2]), .rel_req(ni[1]), .accept_ok(ni[0]), .est_ind(no[9]), .est_cnf(no[8]), .rel_ind(no[7]),
		.rel_cnf(no[6]), .mdl_err(no[5]), .ui_rcvd(no[4]), .seq_clear(no[3]), .data_discard(no[2]),
		.idle_exp(no[1]), .link_up(no[0]));
	usr_entity #(.T200_CYC(T2), .T203_CYC(T3)) usr_entity_i (.sys_clk(sys_clk), .nrst(nrst), .lnk(lk_a.usr_end),
		.est_req(ui[2]), .rel_req(ui[1]), .accept_ok(ui[0]), .est_ind(uo[9]), .est_cnf(uo[8]), .rel_ind(uo[7]),
		.rel_cnf(uo[6]), .mdl_err(uo[5]), .ui_rcvd(uo[4]), .seq_clear(uo[3]), .data_discard(uo[2]),
		.idle_exp(uo[1]), .link_up(uo[0]));
	net_entity #(.T200_CYC(T2), .T203_CYC(T3)) net_entity_b_i (.sys_clk(sys_clk), .nrst(nrst), .lnk(lk_b.net_end),
		.est_req(bi[2]), .rel_req(bi[1]), .accept_ok(bi[0]), .est_ind(bo[9]), .est_cnf(bo[8]), .rel_ind(bo[7]),
		.rel_cnf(bo[6]), .mdl_err(bo[5]), .ui_rcvd(bo[4]), .seq_clear(bo[3]), .data_discard(bo[2]),
		.idle_exp(bo[1]), .link_up(bo[0]));
	lapd_link_monitor lapd_link_monitor_i (.sys_clk(sys_clk), .nrst(nrst), .n2u(lk_a.n2u), .u2n(lk_a.u2n));
	// ********************************
	// Helpers
	// ********************************
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic step(input int n = 1);
		repeat (n) @(negedge sys_clk);
	endtask : step
	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	function automatic logic [9:0] fr(input lapd_pkg::frame_kind_type k, input logic p);
		return {5'h0, 1'b1, k, p};
	endfunction : fr
	// One frame into the lone entity; its answer is then on show
	task automatic rx(input lapd_pkg::frame_kind_type k, input logic p, input logic [9:0] ef, input logic [9:0] eo);
		lk_b.u2n = {1'b1, k, p};
		step();
		lk_b.u2n = '0;
		chk({5'h0, lk_b.n2u}, ef);
		chk(bo, eo);
		step();
	endtask : rx
	// Unanswered command: three resends, then give up
	task automatic tries(input lapd_pkg::frame_kind_type k, input logic [9:0] e);
		step();
		bi[2:1] = 2'h0;
		chk({5'h0, lk_b.n2u}, fr(k, 1'b1));
		for (int i = 0; i < 3; i++) begin
			step(T2 - 1);
			chk({5'h0, lk_b.n2u}, 10'h0);
			step();
			chk({5'h0, lk_b.n2u}, fr(k, 1'b1));
		end
		step(T2);
		chk(bo, e);
	endtask : tries
	// Pair check of both ends, frames then primitives
	task automatic both(input logic [9:0] fn, input logic [9:0] fu, input logic [9:0] on, input logic [9:0] ou);
		chk({5'h0, lk_a.n2u}, fn);
		chk({5'h0, lk_a.u2n}, fu);
		chk(no, on);
		chk(uo, ou);
	endtask : both
	task automatic complete_run();
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	// Hang guard well past the expected run
	initial begin
		repeat (5000) @(posedge sys_clk);
		fails++;
		complete_run();
	end
	// ********************************
	// Scenarios
	// ********************************
	initial begin
		lk_b.u2n = '0;
		step(4);
		nrst = 1'b1;
		ni[2] = 1'b1;
		step();
		ni[2] = 1'b0;
		both(fr(lapd_pkg::FK_SABME, 1'b1), 10'h0, 10'h00c, 10'h0);
		step();
		both(10'h0, fr(lapd_pkg::FK_UA, 1'b1), 10'h0, 10'h209);
		step();
		both(10'h0, 10'h0, 10'h109, 10'h001);
		for (int i = 0; i < 2 * T3 && no[1] !== 1'b1; i++) step();
		chk(no, 10'h003);
		{ni[1], ui[1]} = 2'h3;
		step();
		{ni[1], ui[1]} = 2'h0;
		both(fr(lapd_pkg::FK_DISC, 1'b1), fr(lapd_pkg::FK_DISC, 1'b1), 10'h004, 10'h004);
		step(2);
		both(10'h0, 10'h0, 10'h040, 10'h040);
		{ni[2], ui[2]} = 2'h3;
		step();
		{ni[2], ui[2]} = 2'h0;
		step(2);
		both(10'h0, 10'h0, 10'h109, 10'h109);
		{ni[1], ui[2]} = 2'h3;
		step();
		{ni[1], ui[2]} = 2'h0;
		step();
		both(fr(lapd_pkg::FK_DM, 1'b1), fr(lapd_pkg::FK_DM, 1'b1), 10'h0, 10'h0);
		step();
		both(10'h0, 10'h0, 10'h040, 10'h080);
		rx(lapd_pkg::FK_DM, 1'b0, 10'h0, 10'h0);
		rx(lapd_pkg::FK_UA, 1'b1, 10'h0, 10'h020);
		rx(lapd_pkg::FK_DM, 1'b1, 10'h0, 10'h020);
		rx(lapd_pkg::FK_UI, 1'b0, 10'h0, 10'h010);
		rx(lapd_pkg::FK_SUPV, 1'b0, 10'h0, 10'h0);
		rx(lapd_pkg::FK_INFO, 1'b1, fr(lapd_pkg::FK_DM, 1'b1), 10'h0);
		rx(lapd_pkg::FK_DISC, 1'b0, fr(lapd_pkg::FK_DM, 1'b0), 10'h0);
		bi[0] = 1'b0;
		rx(lapd_pkg::FK_SABME, 1'b0, fr(lapd_pkg::FK_DM, 1'b0), 10'h0);
		bi[0] = 1'b1;
		rx(lapd_pkg::FK_SABME, 1'b0, fr(lapd_pkg::FK_UA, 1'b0), 10'h209);
		rx(lapd_pkg::FK_DISC, 1'b1, fr(lapd_pkg::FK_UA, 1'b1), 10'h080);
		bi[2] = 1'b1;
		tries(lapd_pkg::FK_SABME, 10'h0a4);
		bi[2] = 1'b1;
		step();
		bi[2] = 1'b0;
		rx(lapd_pkg::FK_DM, 1'b0, 10'h0, 10'h0);
		rx(lapd_pkg::FK_DM, 1'b1, 10'h0, 10'h080);
		rx(lapd_pkg::FK_SABME, 1'b1, fr(lapd_pkg::FK_UA, 1'b1), 10'h209);
		bi[1] = 1'b1;
		tries(lapd_pkg::FK_DISC, 10'h060);
		complete_run();
	end
endmodule : lapd_mode_setting_fsm_test
`default_nettype wire
